// >>> include/nvsp_pkg.sv
package nvsp_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // bus timing in ns, cycle counts derived at 100 MHz
  localparam int CLK_PERIOD_NS       = 10;
  localparam int ADDR_SETUP_NS       = 10;
  localparam int ACCESS_NS           = 45;
  localparam int DATA_SETUP_NS       = 20;
  localparam int WRITE_PULSE_NS      = 35;
  localparam int RECOVERY_NS         = 10;
  localparam int STORE_TIME_US       = 10000;
  localparam int RECALL_TIME_US      = 20;

  localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int DATA_SETUP_CYC  = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC    = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_CYC_DEF   = STORE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int RECALL_CYC_DEF  = RECALL_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W           = 24;

  // software sequence addresses
  localparam logic [ADDR_W-1:0] SEQ_ADDR0   = 15'h0e38;
  localparam logic [ADDR_W-1:0] SEQ_ADDR1   = 15'h31c7;
  localparam logic [ADDR_W-1:0] SEQ_ADDR2   = 15'h03e0;
  localparam logic [ADDR_W-1:0] SEQ_ADDR3   = 15'h3c1f;
  localparam logic [ADDR_W-1:0] SEQ_ADDR4   = 15'h303f;
  localparam logic [ADDR_W-1:0] STORE_ADDR  = 15'h0fc0;
  localparam logic [ADDR_W-1:0] RECALL_ADDR = 15'h0c63;

  typedef enum logic [1:0] {
    NVSP_OP_READ   = 2'h0,
    NVSP_OP_WRITE  = 2'h1,
    NVSP_OP_STORE  = 2'h2,
    NVSP_OP_RECALL = 2'h3
  } nvsp_op_t;

  typedef struct packed {
    nvsp_op_t            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } nvsp_req_t;

  typedef struct packed {
    logic                device_select_n;
    logic                output_drive_n;
    logic                write_strobe_n;
    logic [ADDR_W-1:0]   addr_in;
  } nvsp_pins_t;

endpackage

// >>> tb/nvsp_host_asserts.sv
`timescale 1ns/1ps
module nvsp_host_asserts
  import nvsp_pkg::*;
(
  // clock and reset
  input wire logic              clock,
  input wire logic              reset,
  // user side
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  // memory pins
  input wire nvsp_pins_t        pins,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe,
  input wire logic              store_busy_n_in,
  input wire logic              store_busy_n_out,
  input wire logic              store_busy_n_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_read_open;
    $fell(pins.output_drive_n);
  endsequence
  sequence s_read_hold;
    (!pins.output_drive_n && !rsp_valid && $stable(pins.addr_in)) [*5];
  endsequence
  a_read_select: assert property (!pins.output_drive_n |-> !pins.device_select_n && pins.write_strobe_n)
    else $error("read strobe without select");
  a_read_timing: assert property (s_read_open |-> s_read_hold ##[1:4] rsp_valid)
    else $error("read data taken early or never");
  a_idle_deselect: assert property (req_ready |-> pins.device_select_n && pins.write_strobe_n && !data_oe)
    else $error("pins active while idle");
  a_write_quiet: assert property (!pins.write_strobe_n |-> pins.output_drive_n && !pins.device_select_n)
    else $error("bad strobes in write");
  a_write_addr: assert property (!pins.write_strobe_n |-> $stable(pins.addr_in))
    else $error("address moved in write");
  a_data_setup: assert property ($rose(pins.write_strobe_n) |-> data_oe && $past(data_oe, 2) && $stable(data_out))
    else $error("write data not set up");
  a_no_contend: assert property (data_oe |-> pins.output_drive_n)
    else $error("host drives data with output enabled");
  a_busy_refuse: assert property ((!store_busy_n_in) [*3] |-> !req_ready)
    else $error("request taken while store pin low");
  a_pin_release: assert property (store_busy_n_oe |-> !store_busy_n_out)
    else $error("store pin driven high");
endmodule
bind nvsp_host nvsp_host_asserts i_chk (.clock(clock), .reset(reset), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .pins(pins), .data_out(data_out), .data_oe(data_oe), .store_busy_n_in(store_busy_n_in),
  .store_busy_n_out(store_busy_n_out), .store_busy_n_oe(store_busy_n_oe));

// >>> tb/nvsp_mem_model.sv
`timescale 1ns/1ps
module nvsp_mem_model
  import nvsp_pkg::*;
#(
  parameter int ACC_T    = 3,
  parameter int STORE_T  = 30,
  parameter int RECALL_T = 8
)
(
  // clock and power-up
  input  wire logic              clock,
  input  wire logic              power_up,
  // pins
  input  wire nvsp_pins_t        pins,
  input  wire logic [DATA_W-1:0] dq,
  input  wire logic              store_busy_n,
  output logic [DATA_W-1:0]      dev_data,
  output logic                   dev_oe,
  output logic                   hsb_low
);
  logic [DATA_W-1:0] mem [0:32767];
  logic [DATA_W-1:0] nv  [0:32767];
  logic [ADDR_W-1:0] seq [0:4] = '{SEQ_ADDR0, SEQ_ADDR1, SEQ_ADDR2, SEQ_ADDR3, SEQ_ADDR4};
  int                busy;
  int                acc;
  int                idx;
  logic              dirty;
  logic              prev_ce_n;
  logic              prev_we_n;
  logic [ADDR_W-1:0] prev_addr;
  // data appears only after the access delay, so early sampling sees garbage
  assign dev_oe   = !pins.device_select_n && !pins.output_drive_n && pins.write_strobe_n && store_busy_n && busy == 0
                    && acc >= ACC_T;
  assign dev_data = mem[pins.addr_in];
  always @(posedge clock) begin
    prev_ce_n <= pins.device_select_n;
    prev_we_n <= pins.write_strobe_n;
    prev_addr <= pins.addr_in;
    acc <= (!pins.device_select_n && pins.addr_in == prev_addr) ? acc + 1 : 0;
    if (power_up) begin
      // a dirty array is saved as power falls; a clean one is reloaded at power up
      if (dirty === 1'b1)
        nv <= mem;
      else
        mem <= nv;
      busy <= RECALL_T;
      hsb_low <= 1'b0;
      dirty <= 1'b0;
      idx <= 0;
    end else if (busy != 0) begin
      busy <= busy - 1;
      if (busy == 1)
        hsb_low <= 1'b0;
    end else if (!store_busy_n) begin
      if (dirty) begin
        nv <= mem;
        busy <= STORE_T;
        hsb_low <= 1'b1;
        dirty <= 1'b0;
      end
    end else begin
      if (!pins.device_select_n && !pins.write_strobe_n) begin
        mem[pins.addr_in] <= dq;
        dirty <= 1'b1;
        idx <= 0;
      end
      if (!prev_ce_n && pins.device_select_n && prev_we_n) begin
        if (idx == 5 && prev_addr == STORE_ADDR) begin
          nv <= mem;
          busy <= STORE_T;
          hsb_low <= 1'b1;
          dirty <= 1'b0;
          idx <= 0;
        end else if (idx == 5 && prev_addr == RECALL_ADDR) begin
          mem <= nv;
          busy <= RECALL_T;
          dirty <= 1'b0;
          idx <= 0;
        end else if (idx < 5 && prev_addr == seq[idx])
          idx <= idx + 1;
        else
          idx <= (prev_addr == seq[0]) ? 1 : 0;
      end
    end
  end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb
  import nvsp_pkg::*;
;
  logic              clock;
  logic              reset;
  logic              req_valid;
  nvsp_req_t         req;
  logic              req_ready;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  nvsp_pins_t        pins;
  logic [DATA_W-1:0] data_out;
  logic              data_oe;
  logic              hsb_out;
  logic              hsb_oe;
  logic              tb_hsb_low;
  logic              dev_hsb_low;
  logic              dev_oe;
  logic [DATA_W-1:0] dev_data;
  logic [DATA_W-1:0] last_dq;
  logic [DATA_W-1:0] dq;
  logic              store_busy_n;
  int                n_errors;
  int                cmp_count;
  nvsp_host #(.STORE_CYC(20), .RECALL_CYC(10)) i_nvsp_host (.clock(clock), .reset(reset), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .data_in(dq),
    .data_out(data_out), .data_oe(data_oe), .store_busy_n_in(store_busy_n), .store_busy_n_out(hsb_out),
    .store_busy_n_oe(hsb_oe));
  nvsp_mem_model i_nvsp_mem_model (.clock(clock), .power_up(reset), .pins(pins), .dq(dq), .store_busy_n(store_busy_n),
    .dev_data(dev_data), .dev_oe(dev_oe), .hsb_low(dev_hsb_low));
  // an undriven bus flips every cycle so stale data never looks valid
  always @(posedge clock) last_dq <= reset ? 8'h00 : dq;
  assign dq  = data_oe ? data_out : (dev_oe ? dev_data : ~last_dq);
  assign store_busy_n = !(hsb_oe && !hsb_out) && !dev_hsb_low && !tb_hsb_low;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    chk("ready_wait", n < 200, 1);
  endtask
  task automatic xfer(input nvsp_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    int n;
    wait_ready();
    req_valid = 1'b1;
    req = '{op: op, addr: a, wdata: d};
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (op == NVSP_OP_READ && rsp_valid !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    if (op == NVSP_OP_READ) begin
      chk("rsp_wait", n < 50, 1);
    end
    q = rsp_data;
  endtask
  task automatic t_write_read();
    logic [ADDR_W-1:0] a [3] = '{15'h0000, 15'h7fff, 15'h1234};
    logic [DATA_W-1:0] d [3] = '{8'ha5, 8'h5a, 8'h3c};
    logic [DATA_W-1:0] q;
    for (int i = 0; i < 3; i++) begin
      xfer(NVSP_OP_WRITE, a[i], d[i], q);
    end
    for (int i = 0; i < 3; i++) begin
      xfer(NVSP_OP_READ, a[i], 8'h00, q);
      chk("read_data", q, d[i]);
    end
    $display("test write_read done");
  endtask
  task automatic t_soft_ops();
    logic [DATA_W-1:0] q;
    xfer(NVSP_OP_WRITE, 15'h0100, 8'hc3, q);
    xfer(NVSP_OP_STORE, 15'h0000, 8'h00, q);
    xfer(NVSP_OP_WRITE, 15'h0100, 8'h1e, q);
    xfer(NVSP_OP_READ, 15'h0100, 8'h00, q);
    chk("after_store", q, 8'h1e);
    xfer(NVSP_OP_RECALL, 15'h0000, 8'h00, q);
    xfer(NVSP_OP_READ, 15'h0100, 8'h00, q);
    chk("after_recall", q, 8'hc3);
    $display("test soft_ops done");
  endtask
  // pulls the store pin for four cycles, then checks the pin level against exp_busy one cycle after release
  task automatic pulse_hsb(input logic exp_busy);
    wait_ready();
    tb_hsb_low = 1'b1;
    repeat (4) @(negedge clock);
    chk("ready_in_store", req_ready, 1'b0);
    chk("pin_release", hsb_oe, 1'b0);
    tb_hsb_low = 1'b0;
    @(negedge clock);
    chk("busy_pin", store_busy_n, !exp_busy);
  endtask
  task automatic t_hw_store();
    logic [DATA_W-1:0] q;
    pulse_hsb(1'b0);
    xfer(NVSP_OP_WRITE, 15'h0200, 8'h77, q);
    pulse_hsb(1'b1);
    xfer(NVSP_OP_READ, 15'h0200, 8'h00, q);
    chk("read_after_store", q, 8'h77);
    $display("test hw_store done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    tb_hsb_low = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    t_write_read();
    t_soft_ops();
    t_hw_store();
    stop_test();
  end
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule

// >>> verilog/nvsp_host.sv
`timescale 1ns/1ps

// Overview of operation
// RL1: reads drive select and output-enable low with write strobe high.
// RL2: one byte of 32768 addressed by 15 bits, eight data lines.
// RL3: read data sampled only after the address access time.
// RL4: read data sampled after the later of select and output delays.
// RL5: address held and strobes kept steady until read data is captured.
// RL6: writes drive select and write strobe low, store pin high.
// RL7: host holds address stable through the whole write cycle.
// RL8: write data driven a setup time before the write strobe rises.
// RL9: output-enable kept high during every write.
// RL10: device floats outputs after write strobe falls if output-enable low.
// RL11: device drives data only while output-enable low in a read.
// RL12: select high between accesses keeps device idle.
// RL13: device holds store pin low during a store; host waits on it.
// RL14: host pulls store pin low to request a hardware store; hsb_request is tied low, so the host never does.
// RL15: host releases store pin so the weak pull-up holds it high.
// RL16: no accesses issued while a store or recall runs.
// RL17: store and recall are bulk operations, one request each.
// RL18: device stores on power down by itself.
// RL19: device recalls at power up; host waits before first access.
// RL20: software store is six select-controlled reads in exact order.
// RL21: software recall uses the same five reads then the recall address.
// RL22: pin stores may be skipped if nothing was written since last.
// RL23: after store pin falls new writes are withheld until it rises.
// RL24: store and recall durations and delays are parameters.
module nvsp_host
  import nvsp_pkg::*;
#(
  parameter int STORE_CYC  = STORE_CYC_DEF,   // rl24 hooks
  parameter int RECALL_CYC = RECALL_CYC_DEF
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // user request
  input  wire logic              req_valid,
  input  wire nvsp_req_t         req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  // memory pins
  output nvsp_pins_t             pins,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  input  wire logic              store_busy_n_in,
  output logic                   store_busy_n_out,
  output logic                   store_busy_n_oe
);

  typedef enum logic [6:0] {
    ST_BOOT   = 7'h01,
    ST_IDLE   = 7'h02,
    ST_SETUP  = 7'h04,
    ST_STROBE = 7'h08,
    ST_RECOV  = 7'h10,
    ST_HSB    = 7'h20,
    ST_WAIT   = 7'h40
  } nvsp_state_t;

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx, input logic recall);
    case (idx)
      3'h0:    seq_addr = SEQ_ADDR0;
      3'h1:    seq_addr = SEQ_ADDR1;
      3'h2:    seq_addr = SEQ_ADDR2;
      3'h3:    seq_addr = SEQ_ADDR3;
      3'h4:    seq_addr = SEQ_ADDR4;
      default: seq_addr = recall ? RECALL_ADDR : STORE_ADDR;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  nvsp_state_t       state, next_state;
  nvsp_req_t         cur, next_cur;
  logic [2:0]        seq_idx, next_seq_idx;
  nvsp_pins_t        next_pins;
  logic [DATA_W-1:0] next_data_out;
  logic              next_data_oe;
  logic              next_hsb_oe;
  logic              next_req_ready;
  logic              next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_data;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_value;
  logic              tmr_done;
  logic              boot_load;
  logic              next_boot_load;
  logic              hsb_request;

  nvsp_timer u_timer (
    .clock (clock),
    .reset (reset),
    .load  (tmr_load),
    .value (tmr_value),
    .done  (tmr_done)
  );

  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_seq_idx   = seq_idx;
    next_pins      = pins;
    next_data_out  = data_out;
    next_data_oe   = data_oe;
    next_hsb_oe    = store_busy_n_oe;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    tmr_load       = 1'b0;
    tmr_value      = '0;
    next_boot_load = 1'b0;
    case (state)
      ST_BOOT: begin
        // the device recalls at power up; give it the full recall time
        // the timer leaves reset at zero, so it is armed here before it is trusted
        if (boot_load) begin
          tmr_load  = 1'b1;
          tmr_value = cyc(RECALL_CYC); // RL19
        end else if (tmr_done && store_busy_n_in) begin // RL19
          next_state     = ST_IDLE;
          next_req_ready = 1'b1;
        end
      end
      ST_IDLE: begin
        next_req_ready = 1'b1;
        // a store pulled low by anyone blocks new accesses
        if (!store_busy_n_in) begin // RL16 RL23
          next_req_ready = 1'b0;
          next_state     = ST_WAIT;
        end else if (req_valid && req_ready) begin
          next_req_ready = 1'b0;
          next_cur       = req;
          next_seq_idx   = 3'h0;
          if (req.op == NVSP_OP_WRITE) begin
            next_pins.addr_in = req.addr; // RL2 RL7
          end else if (req.op == NVSP_OP_READ) begin
            next_pins.addr_in = req.addr; // RL2
          end else begin
            next_pins.addr_in = seq_addr(3'h0, 1'b0); // RL20 RL21
          end
          tmr_load  = 1'b1;
          tmr_value = cyc(ADDR_SETUP_CYC);
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          next_pins.device_select_n = 1'b0;
          if (cur.op == NVSP_OP_WRITE) begin
            next_pins.output_drive_n = 1'b1; // RL9
            next_pins.write_strobe_n = 1'b0; // RL6
            next_data_out            = cur.wdata;
            next_data_oe             = 1'b1;
            tmr_value                = cyc(WRITE_PULSE_CYC + DATA_SETUP_CYC); // RL8
          end else begin
            // software sequences are select-controlled reads, output stays off
            next_pins.output_drive_n = (cur.op != NVSP_OP_READ); // RL1 RL20
            next_pins.write_strobe_n = 1'b1;
            tmr_value                = cyc(ACCESS_CYC); // RL3 RL4
          end
          tmr_load   = 1'b1;
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tmr_done) begin
          if (cur.op == NVSP_OP_READ) begin
            next_rsp_data  = data_in; // RL5 RL11
            next_rsp_valid = 1'b1;
          end
          // address stays put past the rising edge
          next_pins.device_select_n = 1'b1; // RL7 RL12
          next_pins.write_strobe_n  = 1'b1;
          next_pins.output_drive_n  = 1'b1;
          tmr_load   = 1'b1;
          tmr_value  = cyc(RECOVERY_CYC);
          next_state = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (tmr_done) begin
          next_data_oe = 1'b0;
          if ((cur.op == NVSP_OP_STORE || cur.op == NVSP_OP_RECALL) && seq_idx != 3'h5) begin
            next_seq_idx      = seq_idx + 3'h1;
            next_pins.addr_in = seq_addr(seq_idx + 3'h1, cur.op == NVSP_OP_RECALL); // RL20 RL21
            tmr_load          = 1'b1;
            tmr_value         = cyc(ADDR_SETUP_CYC);
            next_state        = ST_SETUP;
          end else if (cur.op == NVSP_OP_STORE || cur.op == NVSP_OP_RECALL) begin
            // bulk operation now runs; accesses are held off for its full time
            tmr_load   = 1'b1;
            tmr_value  = (cur.op == NVSP_OP_RECALL) ? cyc(RECALL_CYC) : cyc(STORE_CYC); // RL17 RL24
            next_state = ST_BOOT;
          end else begin
            // a store pin already low must not see a ready pulse
            next_req_ready = store_busy_n_in; // RL23
            next_state     = ST_IDLE;
          end
        end
      end
      ST_HSB: begin
        // the device drives the pin low itself once the store starts
        next_hsb_oe = 1'b0; // RL15
        next_state  = ST_WAIT;
      end
      ST_WAIT: begin
        if (store_busy_n_in) begin // RL13
          next_req_ready = 1'b1;
          next_state     = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_BOOT;
      end
    endcase
    // hardware store request: one cycle low pulse on the store pin
    if (state == ST_IDLE && !req_valid && hsb_request) begin // RL14 RL22
      next_hsb_oe    = 1'b1;
      next_req_ready = 1'b0;
      next_state     = ST_HSB;
    end
  end

  assign hsb_request = 1'b0;

  always_ff @(posedge clock) begin
    if (reset) begin
      state            <= ST_BOOT;
      boot_load        <= 1'b1;
      cur              <= '0;
      seq_idx          <= 3'h0;
      pins             <= '{device_select_n: 1'b1, output_drive_n: 1'b1, write_strobe_n: 1'b1, addr_in: '0};
      data_out         <= '0;
      data_oe          <= 1'b0;
      store_busy_n_oe  <= 1'b0;
      req_ready        <= 1'b0;
      rsp_valid        <= 1'b0;
      rsp_data         <= '0;
    end else begin
      state            <= next_state;
      boot_load        <= next_boot_load;
      cur              <= next_cur;
      seq_idx          <= next_seq_idx;
      pins             <= next_pins;
      data_out         <= next_data_out;
      data_oe          <= next_data_oe;
      store_busy_n_oe  <= next_hsb_oe;
      req_ready        <= next_req_ready;
      rsp_valid        <= next_rsp_valid;
      rsp_data         <= next_rsp_data;
    end
  end

  // the pin is only ever pulled low, never driven high
  always_ff @(posedge clock) begin
    store_busy_n_out <= 1'b0;
  end

endmodule

// >>> verilog/nvsp_timer.sv
`timescale 1ns/1ps

// loadable down counter; done is high while the count is zero
module nvsp_timer
  import nvsp_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] value,
  output logic                  done
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = value;
    end else if (count != '0) begin
      next_count = count - 24'h000001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == '0);

endmodule
